//--- include/adc_scf_pkg.sv
//==============================================================
// Purpose: constants and types for the scan/compare/format block
// Assumes: 32-bit Avalon-MM words, 16-bit registers in low bits
// Notes:   one word per register, byte address = offset
package adc_scf_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_INSEL   = 8'h04;
    localparam logic [7:0] OFS_THR_LO  = 8'h08;
    localparam logic [7:0] OFS_THR_HI  = 8'h0C;
    localparam logic [7:0] OFS_FMT     = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFS_BUF     = 8'h40;
    // reset values
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] INSEL_RST  = 16'h0000;
    localparam logic [15:0] THR_RST    = 16'h0000;
    localparam logic [2:0]  FMT_RST    = 3'h0;
    // writable bits of the control register (bit 11 reserved, 10 and 7-4 unused)
    localparam logic [15:0] CTRL_MASK  = 16'hF30F;
    // control field positions
    localparam int AUTOSCAN_ENABLE_BIT = 15;
    localparam int SCAN_IRQ_MODE_HI    = 9;
    localparam int SCAN_IRQ_MODE_LO    = 8;
    localparam int RESULT_WRITE_MODE_HI = 3;
    localparam int RESULT_WRITE_MODE_LO = 2;
    localparam int COMPARE_MODE_HI     = 1;
    localparam int COMPARE_MODE_LO     = 0;
    // input select field positions
    localparam int MUXB_NEG_HI = 15;
    localparam int MUXB_NEG_LO = 13;
    localparam int MUXB_POS_HI = 12;
    localparam int MUXB_POS_LO = 8;
    localparam int MUXA_NEG_HI = 7;
    localparam int MUXA_NEG_LO = 5;
    localparam int MUXA_POS_HI = 4;
    localparam int MUXA_POS_LO = 0;
    // format register fields
    localparam int FMT_SIGNED_BIT = 0;
    localparam int FMT_FRAC_BIT   = 1;
    localparam int FMT_RES12_BIT  = 2;
    // status / interrupt bits
    localparam int ST_SCAN_IRQ = 0;
    localparam int ST_SEQ_DONE = 1;
    localparam int ST_MATCH    = 2;
    localparam int ST_STORED   = 3;
    localparam int ST_W        = 4;
    // reserved positive select code
    localparam logic [4:0] POS_UNUSED = 5'h1F;
    typedef enum logic [1:0] {IRQ_NONE, IRQ_SEQ, IRQ_MATCH, IRQ_SEQ_MATCH} scan_irq_mode_t;
    typedef enum logic [1:0] {WM_LEGACY, WM_CMP_SAVE, WM_CMP_ONLY, WM_RSVD} write_mode_t;
    typedef enum logic [1:0] {CM_NONE, CM_GREATER, CM_INSIDE, CM_OUTSIDE} compare_mode_t;
    typedef enum {S_IDLE, S_START, S_WAIT} scan_state_t;
endpackage

//--- logic/adc_scan_compare_format.sv
//==============================================================
// Purpose: auto-scan, threshold compare and result formatting
//          around a SAR converter core
// Assumes: core runs on CLK, answers START with one DONE pulse
// Notes:   registers reached over Avalon-MM with one wait cycle
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
// Function
// - irq mode selects sequence/compare interrupt
// - write mode selects store always/match/never
// - compare mode: outside, inside, greater than
// - mux B positive select, code 31 unused
// - low byte holds mux A pair likewise
// - 12-bit unsigned fraction, four zero LSBs
// - negative 12-bit: zero unsigned, sign-extended signed integer, left-justified signed fraction
// - 10-bit integer right-justified, zero or sign fill
// - 10-bit fraction left-justified, sign in bit 15
// - negative 10-bit: zero unsigned, sign-extended signed integer, left-justified signed fraction
module adc_scan_compare_format
    import adc_scf_pkg::*;
#(
    parameter int BUF_DEPTH = 4
)(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // avalon-mm slave
    input  wire logic [7:0]  ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [31:0] WRITEDATA,
    output logic      [31:0] READDATA,
    output logic             WAITREQUEST,
    // converter core
    output logic             CONV_START,
    output logic [7:0]       CONV_CHANNEL,
    input  wire logic        CONV_DONE,
    input  wire logic [12:0] CONV_DATA,
    // input multiplexer selects
    output logic [2:0]       MUX_B_NEG_SEL,
    output logic [4:0]       MUX_B_POS_SEL,
    output logic [2:0]       MUX_A_NEG_SEL,
    output logic [4:0]       MUX_A_POS_SEL,
    // interrupt
    output logic             IRQ
);
    localparam int IW = $clog2(BUF_DEPTH);

    //==========================================================
    // registers
    logic [15:0]      ctrl_q, ctrl_d;
    logic [15:0]      insel_q, insel_d;
    logic [15:0]      thr_lo_q, thr_lo_d, thr_hi_q, thr_hi_d;
    logic [2:0]       fmt_q, fmt_d;
    logic [ST_W-1:0]  stat_q, stat_d, irq_en_q, irq_en_d;
    logic [15:0]      buf_q [BUF_DEPTH];
    logic [15:0]      buf_wdata;
    logic             buf_we;
    logic [31:0]      rdata_q, rdata_d;
    logic             wait_q, wait_d;
    logic             irq_q, irq_d;

    logic             wr_acc;
    logic             autoscan;
    scan_irq_mode_t   irq_mode;
    write_mode_t      wmode;
    compare_mode_t    cmode;

    assign wr_acc   = WRITE && !wait_q;
    assign autoscan = ctrl_q[AUTOSCAN_ENABLE_BIT];
    assign irq_mode = scan_irq_mode_t'(ctrl_q[SCAN_IRQ_MODE_HI:SCAN_IRQ_MODE_LO]);
    assign wmode    = write_mode_t'(ctrl_q[RESULT_WRITE_MODE_HI:RESULT_WRITE_MODE_LO]);
    assign cmode    = compare_mode_t'(ctrl_q[COMPARE_MODE_HI:COMPARE_MODE_LO]);

    //==========================================================
    // result formatting
    logic [15:0] fmt_word;
    logic        neg;
    always_comb
    begin
        if (fmt_q[FMT_RES12_BIT])
        begin
            neg = CONV_DATA[12];
            case (fmt_q[1:0])
                2'h0: fmt_word = neg ? 16'h0000 : {4'h0, CONV_DATA[11:0]};
                2'h1: fmt_word = {{3{CONV_DATA[12]}}, CONV_DATA};
                2'h2: fmt_word = neg ? 16'h0000 : {CONV_DATA[11:0], 4'h0};
                default: fmt_word = {CONV_DATA, 3'h0};
            endcase
        end
        else
        begin
            neg = CONV_DATA[10];
            case (fmt_q[1:0])
                2'h0: fmt_word = neg ? 16'h0000 : {6'h00, CONV_DATA[9:0]};
                2'h1: fmt_word = {{5{CONV_DATA[10]}}, CONV_DATA[10:0]};
                2'h2: fmt_word = neg ? 16'h0000 : {CONV_DATA[9:0], 6'h00};
                default: fmt_word = {CONV_DATA[10:0], 5'h00};
            endcase
        end
    end

    //==========================================================
    // threshold compare; signed formats compare as signed words
    logic match;
    logic gt_lo, lt_lo, gt_hi;
    always_comb
    begin
        if (fmt_q[FMT_SIGNED_BIT])
        begin
            gt_lo = $signed(fmt_word) > $signed(thr_lo_q);
            lt_lo = $signed(fmt_word) < $signed(thr_lo_q);
            gt_hi = $signed(fmt_word) > $signed(thr_hi_q);
        end
        else
        begin
            gt_lo = fmt_word > thr_lo_q;
            lt_lo = fmt_word < thr_lo_q;
            gt_hi = fmt_word > thr_hi_q;
        end
        case (cmode)
            CM_GREATER: match = gt_lo;
            CM_INSIDE:  match = !lt_lo && !gt_hi;
            CM_OUTSIDE: match = lt_lo || gt_hi;
            default:    match = 1'b0;
        endcase
    end

    //==========================================================
    // scan sequencer
    scan_state_t      st_q, st_d;
    logic [IW-1:0]    idx_q, idx_d;
    logic             start_q, start_d;
    logic             seq_match_q, seq_match_d;
    logic             ev_seq, ev_match, ev_irq;
    logic             last;

    assign last = (idx_q == IW'(BUF_DEPTH - 1));

    always_comb
    begin
        st_d        = st_q;
        idx_d       = idx_q;
        start_d     = 1'b0;
        seq_match_d = seq_match_q;
        ev_seq      = 1'b0;
        ev_match    = 1'b0;
        buf_we      = 1'b0;
        buf_wdata   = fmt_word;
        case (st_q)
            S_IDLE:
            begin
                if (autoscan)
                begin
                    st_d  = S_START;
                    idx_d = '0;
                    seq_match_d = 1'b0;
                end
            end
            S_START:
            begin
                start_d = 1'b1;
                st_d    = S_WAIT;
            end
            S_WAIT:
            begin
                if (CONV_DONE)
                begin
                    ev_match = match && (wmode != WM_RSVD);
                    case (wmode)
                        WM_LEGACY:   buf_we = 1'b1;
                        WM_CMP_SAVE: buf_we = match;
                        default:     buf_we = 1'b0;
                    endcase
                    if (ev_match)
                        seq_match_d = 1'b1;
                    if (last)
                    begin
                        ev_seq = 1'b1;
                        idx_d  = '0;
                        // a match only counts for the sequence it occurred in
                        seq_match_d = 1'b0;
                    end
                    else
                        idx_d = idx_q + IW'(1);
                    // clearing the enable ends the scan after the current conversion
                    st_d = autoscan ? S_START : S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
        case (irq_mode)
            IRQ_SEQ:       ev_irq = ev_seq;
            IRQ_MATCH:     ev_irq = ev_match;
            IRQ_SEQ_MATCH: ev_irq = ev_seq && (seq_match_q || ev_match);
            default:       ev_irq = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st_q        <= S_IDLE;
            idx_q       <= '0;
            start_q     <= 1'b0;
            seq_match_q <= 1'b0;
        end
        else
        begin
            st_q        <= st_d;
            idx_q       <= idx_d;
            start_q     <= start_d;
            seq_match_q <= seq_match_d;
        end
    end

    // result buffer has no reset; reads before the first store are undefined
    always_ff @(posedge CLK)
    begin
        if (buf_we)
            buf_q[idx_q] <= buf_wdata;
    end

    //==========================================================
    // register file and bus slave
    logic [15:0] buf_rd;
    logic [ST_W-1:0] clr;
    always_comb
    begin
        ctrl_d   = ctrl_q;
        insel_d  = insel_q;
        thr_lo_d = thr_lo_q;
        thr_hi_d = thr_hi_q;
        fmt_d    = fmt_q;
        irq_en_d = irq_en_q;
        clr      = '0;
        buf_rd   = 16'h0000;
        if (ADDRESS >= OFS_BUF && ADDRESS < OFS_BUF + 8'(4 * BUF_DEPTH))
            buf_rd = buf_q[IW'((ADDRESS - OFS_BUF) >> 2)];
        if (wr_acc)
        begin
            case (ADDRESS)
                OFS_CTRL:    ctrl_d   = WRITEDATA[15:0] & CTRL_MASK;
                // selects pass straight to the multiplexer
                OFS_INSEL:   insel_d  = WRITEDATA[15:0];
                OFS_THR_LO:  thr_lo_d = WRITEDATA[15:0];
                OFS_THR_HI:  thr_hi_d = WRITEDATA[15:0];
                OFS_FMT:     fmt_d    = WRITEDATA[2:0];
                OFS_IRQ_EN:  irq_en_d = WRITEDATA[ST_W-1:0];
                OFS_IRQ_CLR: clr      = WRITEDATA[ST_W-1:0];
                default:     ;
            endcase
        end
        // set wins over a clear in the same cycle
        stat_d = (stat_q & ~clr)
               | {ST_W'(buf_we) << ST_STORED}
               | {ST_W'(ev_match) << ST_MATCH}
               | {ST_W'(ev_seq) << ST_SEQ_DONE}
               | {ST_W'(ev_irq) << ST_SCAN_IRQ};
        irq_d  = |(stat_d & irq_en_d);
        wait_d = !((READ || WRITE) && wait_q);
        rdata_d = rdata_q;
        if ((READ || WRITE) && wait_q)
        begin
            case (ADDRESS)
                OFS_CTRL:    rdata_d = {16'h0000, ctrl_q};
                OFS_INSEL:   rdata_d = {16'h0000, insel_q};
                OFS_THR_LO:  rdata_d = {16'h0000, thr_lo_q};
                OFS_THR_HI:  rdata_d = {16'h0000, thr_hi_q};
                OFS_FMT:     rdata_d = {29'h0, fmt_q};
                OFS_STATUS:  rdata_d = {28'h0, stat_q};
                OFS_IRQ_EN:  rdata_d = {28'h0, irq_en_q};
                default:     rdata_d = {16'h0000, buf_rd};
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ctrl_q   <= CTRL_RST;
            insel_q  <= INSEL_RST;
            thr_lo_q <= THR_RST;
            thr_hi_q <= THR_RST;
            fmt_q    <= FMT_RST;
            irq_en_q <= '0;
            stat_q   <= '0;
            irq_q    <= 1'b0;
            wait_q   <= 1'b1;
            rdata_q  <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            insel_q  <= insel_d;
            thr_lo_q <= thr_lo_d;
            thr_hi_q <= thr_hi_d;
            fmt_q    <= fmt_d;
            irq_en_q <= irq_en_d;
            stat_q   <= stat_d;
            irq_q    <= irq_d;
            wait_q   <= wait_d;
            rdata_q  <= rdata_d;
        end
    end

    //==========================================================
    // outputs
    assign READDATA      = rdata_q;
    assign WAITREQUEST   = wait_q;
    assign IRQ           = irq_q;
    assign CONV_START    = start_q;
    assign CONV_CHANNEL  = 8'(idx_q);
    assign MUX_B_NEG_SEL = insel_q[MUXB_NEG_HI:MUXB_NEG_LO];
    assign MUX_B_POS_SEL = insel_q[MUXB_POS_HI:MUXB_POS_LO];
    assign MUX_A_NEG_SEL = insel_q[MUXA_NEG_HI:MUXA_NEG_LO];
    assign MUX_A_POS_SEL = insel_q[MUXA_POS_HI:MUXA_POS_LO];
endmodule

//--- dv/adc_scf_checker.sv
//==============================================================
// Purpose: port-level checks of bus, scan and select behaviour
// Assumes: one clock; shadows mirror register writes
// Notes:   bound from the bench top
`timescale 1ns/1ns
module adc_scf_checker
    import adc_scf_pkg::*;
#(
    parameter int BUF_DEPTH = 4
)(
    // clock and reset
    input wire logic        CLK,
    input wire logic        ARST_N,
    // register bus
    input wire logic [7:0]  ADDRESS,
    input wire logic        READ,
    input wire logic        WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic        WAITREQUEST,
    // converter, selects, interrupt
    input wire logic        CONV_START,
    input wire logic [7:0]  CONV_CHANNEL,
    input wire logic        CONV_DONE,
    input wire logic [2:0]  MUX_B_NEG_SEL,
    input wire logic [4:0]  MUX_B_POS_SEL,
    input wire logic [2:0]  MUX_A_NEG_SEL,
    input wire logic [4:0]  MUX_A_POS_SEL,
    input wire logic        IRQ
);
    logic        wr_ack, ins_wr, scan_q;
    logic [2:0]  hist_q;
    logic [15:0] insel_q;
    logic [3:0]  irq_en_q;
    assign wr_ack = WRITE && !WAITREQUEST;
    assign ins_wr = wr_ack && (ADDRESS == OFS_INSEL);
    // shadows commit at the ack edge; history lets an in-flight scan finish
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            scan_q   <= 1'b0;
            hist_q   <= 3'h0;
            insel_q  <= INSEL_RST;
            irq_en_q <= 4'h0;
        end
        else
        begin
            hist_q <= {hist_q[1:0], scan_q};
            if (wr_ack && ADDRESS == OFS_CTRL)
                scan_q <= WRITEDATA[AUTOSCAN_ENABLE_BIT];
            if (ins_wr)
                insel_q <= WRITEDATA[15:0];
            if (wr_ack && ADDRESS == OFS_IRQ_EN)
                irq_en_q <= WRITEDATA[3:0];
        end
    end
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    sequence req_pending;
        (READ || WRITE) && WAITREQUEST;
    endsequence
    sequence done_while_on;
        CONV_DONE && scan_q ##1 scan_q [*2];
    endsequence
    one_wait_a: assert property (req_pending |=> !WAITREQUEST)
        else $error("bus answer not after one wait cycle");
    start_pulse_a: assert property (CONV_START |=> !CONV_START)
        else $error("start pulse wider than one cycle");
    start_enabled_a: assert property (CONV_START |-> scan_q || hist_q != 3'h0)
        else $error("conversion started while scan is off");
    restart_a: assert property (done_while_on |-> ##[0:1] CONV_START)
        else $error("scan did not restart after done");
    channel_range_a: assert property (CONV_START |-> CONV_CHANNEL < BUF_DEPTH)
        else $error("scan index out of range");
    mux_b_a: assert property (!$past(ins_wr) |-> {MUX_B_NEG_SEL, MUX_B_POS_SEL} == insel_q[15:8])
        else $error("mux b selects differ from register");
    mux_a_a: assert property (!$past(ins_wr) |-> {MUX_A_NEG_SEL, MUX_A_POS_SEL} == insel_q[7:0])
        else $error("mux a selects differ from register");
    irq_masked_a: assert property (irq_en_q == 4'h0 && $past(irq_en_q) == 4'h0 |-> !IRQ)
        else $error("interrupt high while all enables off");
endmodule

//--- dv/conv_core_model.sv
//==============================================================
// Purpose: converter core model on the block's far side
// Assumes: start sampled on CLK, one done pulse per start
// Notes:   answers alternate between prompt and slow
`timescale 1ns/1ns
module conv_core_model (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // block side
    input  wire logic        CONV_START,
    output logic             CONV_DONE,
    output logic [12:0]      CONV_DATA,
    // bench side
    input  wire logic [12:0] RAW
);
    logic [3:0] cnt_q;
    logic       slow_q;
    // outside the done cycle the lines show the inverse, so stale data never passes
    assign CONV_DATA = CONV_DONE ? RAW : ~RAW;
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cnt_q     <= 4'h0;
            slow_q    <= 1'b0;
            CONV_DONE <= 1'b0;
        end
        else
        begin
            CONV_DONE <= (cnt_q == 4'h1);
            if (CONV_START)
                cnt_q <= slow_q ? 4'h7 : 4'h1;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1)
                slow_q <= !slow_q;
        end
    end
endmodule

//--- dv/test_adc_scan_compare_format.sv
//==============================================================
// Purpose: self-checking bench for the scan, compare and format block
// Assumes: converter core model on the far side, four buffer slots
// Notes:   reads queue their expected word; a monitor compares at the ack
`timescale 1ns/1ns
module test_adc_scan_compare_format
    import adc_scf_pkg::*;
;
    localparam int BUF_DEPTH = 4;
    logic        CLK, ARST_N, READ, WRITE, WAITREQUEST, CONV_START, CONV_DONE, IRQ;
    logic [7:0]  ADDRESS, CONV_CHANNEL;
    logic [31:0] WRITEDATA, READDATA, v;
    logic [12:0] CONV_DATA, raw;
    logic [4:0]  MUX_B_POS_SEL, MUX_A_POS_SEL;
    logic [2:0]  MUX_B_NEG_SEL, MUX_A_NEG_SEL;
    logic [1:0]  im, wm;
    logic        m, ev, en;
    logic [31:0] exp_q[$];
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    adc_scan_compare_format #(.BUF_DEPTH(BUF_DEPTH)) adc_scan_compare_format_inst (
        .CLK(CLK), .ARST_N(ARST_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
        .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE),
        .CONV_DATA(CONV_DATA), .MUX_B_NEG_SEL(MUX_B_NEG_SEL), .MUX_B_POS_SEL(MUX_B_POS_SEL),
        .MUX_A_NEG_SEL(MUX_A_NEG_SEL), .MUX_A_POS_SEL(MUX_A_POS_SEL), .IRQ(IRQ));
    conv_core_model conv_core_model_inst (.CLK(CLK), .ARST_N(ARST_N), .RAW(raw),
        .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA));
    //==============================================================
    // checks and bus cycles
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDRESS   <= a;
        WRITEDATA <= d;
        WRITE     <= wr;
        READ      <= !wr;
        @(posedge CLK);
        while (WAITREQUEST !== 1'b0)
            @(posedge CLK);
        WRITE <= 1'b0;
        READ  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic scan(input logic [15:0] ctl);
        wr(OFS_CTRL, {16'h0, ctl | 16'h8000});
        repeat (BUF_DEPTH + 1) @(posedge CLK iff CONV_START === 1'b1);
        wr(OFS_CTRL, {16'h0, ctl});
        // the last conversion may still be in flight; let it land first
        repeat (12) @(posedge CLK);
    endtask
    function automatic logic [15:0] fexp(input logic [2:0] f, input logic [12:0] r);
        if (!f[0] && (f[2] ? r[12] : r[10]))
            return 16'h0000;
        case (f[2:1])
            2'b00: return f[0] ? {{5{r[10]}}, r[10:0]} : {6'h00, r[9:0]};
            2'b01: return f[0] ? {r[10:0], 5'h00} : {r[9:0], 6'h00};
            2'b10: return f[0] ? {{3{r[12]}}, r[12:0]} : {4'h0, r[11:0]};
            default: return f[0] ? {r[12:0], 3'h0} : {r[11:0], 4'h0};
        endcase
    endfunction
    //==============================================================
    // monitor, clock and guard
    always @(posedge CLK)
        if (READ && WAITREQUEST === 1'b0)
            check(READDATA, exp_q.pop_front());
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            fail_count++;
            summarize();
        end
    end
    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    //==============================================================
    // main sequence
    initial
    begin
        {ARST_N, READ, WRITE, ADDRESS, WRITEDATA, raw} = '0;
        void'($urandom(32'h12F2));
        repeat (20) @(posedge CLK);
        ARST_N <= 1'b1;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_INSEL, 32'h0);
        wr(OFS_CTRL, 32'h7FFF);
        rd(OFS_CTRL, {16'h0, 16'h7FFF & CTRL_MASK});
        wr(OFS_STATUS, 32'hF);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_IRQ_CLR, 32'h0);
        rd(8'h24, 32'h0);
        $display("register test done");
        repeat (4)
        begin
            v = $urandom;
            if (v[12:8] == POS_UNUSED)
                v[12:8] = 5'h1D;
            wr(OFS_INSEL, v);
            rd(OFS_INSEL, {16'h0, v[15:0]});
        end
        $display("input select test done");
        for (int f = 0; f < 8; f++)
            for (int s = 0; s < 2; s++)
            begin
                v = $urandom;
                v[12] = s[0];
                v[10] = s[0];
                wr(OFS_FMT, 32'(f));
                raw <= v[12:0];
                scan(16'h0000);
                rd(OFS_BUF, {16'h0, fexp(3'(f), v[12:0])});
                rd(OFS_BUF + 8'(4 * BUF_DEPTH - 4), {16'h0, fexp(3'(f), v[12:0])});
            end
        $display("format test done");
        wr(OFS_FMT, 32'h0);
        wr(OFS_THR_LO, 32'h100);
        wr(OFS_THR_HI, 32'h300);
        raw <= 13'h0200;
        for (int i = 0; i < 4; i++)
        begin
            m  = (i == 1) || (i == 2);
            im = 2'(i) ^ 2'b01;
            wm = i[0] ? 2'b10 : 2'b01;
            ev = (im == 2'b01) || (im[1] && m);
            en = (i != 2);
            wr(OFS_IRQ_CLR, 32'hF);
            wr(OFS_IRQ_EN, {31'h0, en});
            scan({6'h00, im, 4'h0, wm, 2'(i)});
            rd(OFS_STATUS, {28'h0, m && (wm == 2'b01), m, 1'b1, ev});
            check(IRQ, ev && en);
            wr(OFS_IRQ_CLR, 32'hF);
            rd(OFS_STATUS, 32'h0);
            check(IRQ, 1'b0);
        end
        // mode 11 needs a match inside each sequence, not one left from the last
        raw <= 13'h0200;
        wr(OFS_CTRL, 32'h8309);
        repeat (BUF_DEPTH) @(posedge CLK iff CONV_START === 1'b1);
        raw <= 13'h0000;
        @(posedge CLK iff CONV_START === 1'b1);
        wr(OFS_IRQ_CLR, 32'hF);
        repeat (BUF_DEPTH) @(posedge CLK iff CONV_START === 1'b1);
        wr(OFS_CTRL, 32'h0);
        repeat (12) @(posedge CLK);
        rd(OFS_STATUS, 32'h2);
        check(IRQ, 1'b0);
        $display("compare and interrupt test done");
        summarize();
    end
endmodule
bind adc_scan_compare_format adc_scf_checker #(.BUF_DEPTH(BUF_DEPTH)) adc_scf_checker_inst (
    .CLK(CLK), .ARST_N(ARST_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .WAITREQUEST(WAITREQUEST), .CONV_START(CONV_START),
    .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE), .MUX_B_NEG_SEL(MUX_B_NEG_SEL),
    .MUX_B_POS_SEL(MUX_B_POS_SEL), .MUX_A_NEG_SEL(MUX_A_NEG_SEL),
    .MUX_A_POS_SEL(MUX_A_POS_SEL), .IRQ(IRQ));
